// >>> rtl/ctat_pkg.sv
// Constants and types of the host-side tag command issuer.
// Assumes a byte-serial command link to the coupler, one byte a handshake.
package ctat_pkg;
    localparam logic [7:0] CLA_PROP = 8'hff;
    localparam logic [7:0] INS_READ = 8'hb0;
    localparam logic [7:0] INS_UPDATE = 8'hd6;
    localparam logic [7:0] INS_SLOT = 8'hfb;
    localparam logic [7:0] INS_PASS = 8'hfe;
    localparam logic [7:0] SLOT_RESET_P1 = 8'h10;
    localparam logic [7:0] SLOT_RESET_P2 = 8'h02;
    localparam logic [7:0] SLOT_TCL_P1 = 8'h20;
    localparam logic [7:0] SLOT_TCL_P2 = 8'h01;
    localparam logic [7:0] LE_WHOLE_DATA = 8'h78;
    localparam logic [7:0] LE_WHOLE_FULL = 8'h7a;
    localparam logic [7:0] LE_SEGMENT = 8'h80;
    localparam logic [7:0] LE_BLOCK = 8'h08;
    localparam logic [7:0] LE_BYTE = 8'h01;
    localparam logic [7:0] LEN_PAGE = 8'h04;
    localparam logic [7:0] P1_XOR = 8'h80;
    localparam logic [7:0] HDR_STATIC = 8'h11;
    localparam logic [3:0] HDR_FAMILY = 4'h1;
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [7:0] PROBE_STEP = 8'h04;
    localparam logic [7:0] PROBE_LAST = 8'hfc;
    localparam logic [8:0] PROBE_FULL = 9'h100;
    localparam logic [3:0] FRAME_HDR = 4'h5;
    localparam int FRAME_MAX = 13;
    localparam int HEAD_BYTES = 8;
    localparam logic [2:0] HEAD_IDX_MAX = 3'h7;

    typedef enum logic [3:0] {
        OP_PAGE_READ = 4'h0,
        OP_PAGE_WRITE = 4'h1,
        OP_PROBE = 4'h2,
        OP_HDR_FETCH = 4'h3,
        OP_WHOLE_READ = 4'h4,
        OP_BYTE_READ = 4'h5,
        OP_SEG_READ = 4'h6,
        OP_BLOCK_READ = 4'h7,
        OP_BYTE_WRITE = 4'h8,
        OP_BLOCK_WRITE = 4'h9,
        OP_SLOT_RESET = 4'ha,
        OP_SLOT_TCL = 4'hb,
        OP_PASS = 4'hc
    } ctat_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SEND = 3'b001,
        S_WAIT = 3'b011,
        S_EVAL = 3'b010,
        S_FIN = 3'b110
    } ctat_state_t;
endpackage

// >>> rtl/ctat_rsp_sink.sv
// Response collector: keeps the first eight bytes and the trailing status word.
// Assumes rx_last marks the final byte of every response frame.
`timescale 1ns/10ps
module ctat_rsp_sink
    import ctat_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rsp_done,
    output logic [63:0] rsp_head,
    output logic [15:0] rsp_sw
);
    logic [3:0] idx;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx <= 4'h0;
            rsp_head <= 64'h0;
            rsp_sw <= 16'h0;
            rsp_done <= 1'b0;
        end else begin
            rsp_done <= rx_valid && rx_last;
            if (rx_valid) begin
                rsp_sw <= {rsp_sw[7:0], rx_data};
                if (idx < 4'(HEAD_BYTES))
                    rsp_head[63 - 8 * idx[2:0] -: 8] <= rx_data;
                if (rx_last)
                    idx <= 4'h0;
                else if (idx < 4'(HEAD_BYTES))
                    idx <= idx + 4'h1;
            end
        end
    end
endmodule

// >>> rtl/ctat_host.sv
// Host issuer of read, update, slot and passthrough frames to a tag coupler.
// Assumes the coupler answers every frame with a two-byte status word, preceded by data for read frames only.
// Operation
// R1 - Page tag P1 is the sector; zero when tag has one sector.
// R2 - Page read length multiple of four; zero yields sixteen bytes.
// R3 - Le 0x40 or 0x90 returns whole page-tag data area.
// R4 - Page update writes one page at P2 with exactly four bytes.
// R5 - Page memory in four-byte pages, 256-page sectors.
// R6 - Probe capacity reading upward; wrap shows as pages 16,17 matching 0,1.
// R7 - Static header tag: 120 bytes, whole, byte and byte-write functions only.
// R8 - Dynamic header tag adds block, segment and eight-byte write functions.
// R9 - Header 0x11 static, 0x1y dynamic, others reserved.
// R10 - Fetch the first header byte before any data access.
// R11 - Whole read with Le 0 or 0x78 returns 120 data bytes.
// R12 - Whole read with Le 0x7A returns both header bytes and data.
// R13 - Byte read Le 1 at byte address 0 to 127.
// R14 - Segment read Le 0x80, address multiple of 128, dynamic only.
// R15 - Block read Le 8, address multiple of eight, dynamic only.
// R16 - Level 0 card takes native commands in passthrough with P1 zero.
// R17 - After personalisation request field reset with slot parameters 10,02.
// R18 - Level 1 AES authentication via passthrough with P1 one.
// R19 - Raise level by forcing session with slot parameters 20,01.
// R20 - Level 2 only through raw slot and passthrough instructions.
// R21 - Level 3 native commands in passthrough with P1 zero.
// R22 - Triple-DES authentication relayed via passthrough with P1 one.
// R23 - Byte update of length one, P1 zero, erases and writes.
// R24 - P1 bit 7 selects the exclusive-or write.
// R25 - Dynamic eight-byte update at address multiple of eight.
// R26 - Mismatched length or alignment is refused with an error.
`timescale 1ns/10ps
module ctat_host
    import ctat_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [3:0] req_op,
    input wire logic [7:0] req_sector,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_len,
    input wire logic req_xor,
    input wire logic [63:0] req_data,
    input wire logic multi_sector,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic req_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic done,
    output logic done_ok,
    output logic refused,
    output logic [15:0] status_word,
    output logic hdr_known,
    output logic hdr_dynamic,
    output logic [7:0] header_byte_first,
    output logic [8:0] capacity_pages
);
    ctat_state_t state;
    ctat_op_t cur_op;
    logic [7:0] frame [0:FRAME_MAX-1];
    logic [3:0] frame_len;
    logic [3:0] idx;
    logic [7:0] page;
    logic [63:0] ref_head;
    logic cur_multi;
    logic rsp_done;
    logic [63:0] rsp_head;
    logic [15:0] rsp_sw;
    logic accept;
    logic legal;
    logic rsp_ok;

    function automatic logic ctat_is_type1(input logic [3:0] op);
        return op inside {OP_WHOLE_READ, OP_BYTE_READ, OP_SEG_READ, OP_BLOCK_READ,
                          OP_BYTE_WRITE, OP_BLOCK_WRITE};
    endfunction

    function automatic logic ctat_legal(input logic [3:0] op, input logic [7:0] sec,
                                        input logic [15:0] addr, input logic [7:0] len,
                                        input logic multi, input logic known,
                                        input logic dyn);
        logic ok;
        ok = 1'b0;
        case (op)
            // R2 R3 whole pages only
            OP_PAGE_READ: ok = (len[1:0] == 2'b00) && (multi || sec == 8'h00);
            OP_PAGE_WRITE: ok = (len == LEN_PAGE) && (multi || sec == 8'h00);
            OP_PROBE: ok = multi || sec == 8'h00;
            OP_HDR_FETCH: ok = 1'b1;
            OP_WHOLE_READ: ok = len inside {8'h00, LE_WHOLE_DATA, LE_WHOLE_FULL};
            OP_BYTE_READ: ok = (addr[15:7] == 9'h0);
            OP_BYTE_WRITE: ok = (addr[15:7] == 9'h0);
            // R7 R8 dynamic-only functions
            OP_SEG_READ: ok = dyn && (addr[6:0] == 7'h0);
            OP_BLOCK_READ: ok = dyn && (addr[2:0] == 3'h0);
            OP_BLOCK_WRITE: ok = dyn && (addr[15] == 1'b0) && (addr[2:0] == 3'h0);
            OP_SLOT_RESET: ok = 1'b1;
            OP_SLOT_TCL: ok = 1'b1;
            // R20 R21 raw passthrough only
            OP_PASS: ok = (sec[7:1] == 7'h0) && (len != 8'h00) && (len <= 8'h08);
            default: ok = 1'b0;
        endcase
        // R10 header first
        if (ctat_is_type1(op) && !known)
            ok = 1'b0;
        return ok;
    endfunction

    assign accept = req_valid && req_ready;
    // R26 refuse mismatch
    assign legal = ctat_legal(req_op, req_sector, req_addr, req_len, multi_sector,
                              hdr_known, hdr_dynamic);
    assign rsp_ok = (rsp_sw == SW_OK);

    ctat_rsp_sink u_sink (
        .core_clk(core_clk),
        .rst(rst),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_last(rx_last),
        .rsp_done(rsp_done),
        .rsp_head(rsp_head),
        .rsp_sw(rsp_sw)
    );

    // Frame assembly at acceptance and probe re-issue
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < FRAME_MAX; i++)
                frame[i] <= 8'h00;
            frame_len <= FRAME_HDR;
        end else if (accept && legal) begin
            frame[0] <= CLA_PROP;
            frame[1] <= INS_READ;
            frame[2] <= 8'h00;
            frame[3] <= req_addr[7:0];
            frame[4] <= req_len;
            frame_len <= FRAME_HDR;
            for (int i = 0; i < HEAD_BYTES; i++)
                frame[5 + i] <= req_data[63 - 8 * i -: 8];
            case (req_op)
                // R1 R5 sector byte
                OP_PAGE_READ: frame[2] <= req_sector;
                OP_PAGE_WRITE: begin
                    // R4 one page
                    frame[1] <= INS_UPDATE;
                    frame[2] <= req_sector;
                    frame[4] <= LEN_PAGE;
                    frame_len <= FRAME_HDR + 4'h4;
                end
                OP_PROBE: begin
                    frame[2] <= req_sector;
                    frame[3] <= 8'h00;
                    frame[4] <= 8'h00;
                end
                OP_HDR_FETCH: begin
                    // R12 full frame
                    frame[3] <= 8'h00;
                    frame[4] <= LE_WHOLE_FULL;
                end
                // R11 whole read
                OP_WHOLE_READ: frame[3] <= 8'h00;
                // R13 byte read
                OP_BYTE_READ: frame[4] <= LE_BYTE;
                OP_SEG_READ: begin
                    // R14 segment read
                    frame[2] <= req_addr[15:8];
                    frame[4] <= LE_SEGMENT;
                end
                OP_BLOCK_READ: begin
                    // R15 block read
                    frame[2] <= req_addr[15:8];
                    frame[4] <= LE_BLOCK;
                end
                OP_BYTE_WRITE: begin
                    // R23 R24 byte write
                    frame[1] <= INS_UPDATE;
                    frame[2] <= req_xor ? P1_XOR : 8'h00;
                    frame[4] <= LE_BYTE;
                    frame_len <= FRAME_HDR + 4'h1;
                end
                OP_BLOCK_WRITE: begin
                    // R25 block write
                    frame[1] <= INS_UPDATE;
                    frame[2] <= {req_xor, req_addr[14:8]};
                    frame[4] <= LE_BLOCK;
                    frame_len <= FRAME_HDR + 4'h8;
                end
                OP_SLOT_RESET: begin
                    // R17 field reset
                    frame[1] <= INS_SLOT;
                    frame[2] <= SLOT_RESET_P1;
                    frame[3] <= SLOT_RESET_P2;
                    frame[4] <= 8'h00;
                end
                OP_SLOT_TCL: begin
                    // R19 force session
                    frame[1] <= INS_SLOT;
                    frame[2] <= SLOT_TCL_P1;
                    frame[3] <= SLOT_TCL_P2;
                    frame[4] <= 8'h00;
                end
                OP_PASS: begin
                    // R16 R18 R22 passthrough
                    frame[1] <= INS_PASS;
                    frame[2] <= req_sector;
                    frame[3] <= 8'h00;
                    frame_len <= FRAME_HDR + req_len[3:0];
                end
                default: frame[4] <= 8'h00;
            endcase
        end else if (state == S_EVAL && cur_op == OP_PROBE) begin
            frame[3] <= page + PROBE_STEP;
        end
    end

    // Sequencing, link bytes and results
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            cur_op <= OP_PAGE_READ;
            cur_multi <= 1'b0;
            idx <= 4'h0;
            page <= 8'h00;
            ref_head <= 64'h0;
            req_ready <= 1'b1;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            done <= 1'b0;
            done_ok <= 1'b0;
            refused <= 1'b0;
            status_word <= 16'h0;
            hdr_known <= 1'b0;
            hdr_dynamic <= 1'b0;
            header_byte_first <= 8'h00;
            capacity_pages <= 9'h0;
        end else begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        req_ready <= 1'b0;
                        cur_op <= ctat_op_t'(req_op);
                        cur_multi <= multi_sector;
                        idx <= 4'h0;
                        page <= 8'h00;
                        refused <= !legal;
                        state <= legal ? S_SEND : S_FIN;
                    end
                end
                S_SEND: begin
                    if (!tx_valid) begin
                        tx_valid <= 1'b1;
                        tx_data <= frame[idx];
                        tx_last <= (idx == frame_len - 4'h1);
                    end else if (tx_ready) begin
                        if (tx_last) begin
                            tx_valid <= 1'b0;
                            tx_last <= 1'b0;
                            state <= S_WAIT;
                        end else begin
                            idx <= idx + 4'h1;
                            tx_data <= frame[idx + 4'h1];
                            tx_last <= (idx + 4'h1 == frame_len - 4'h1);
                        end
                    end
                end
                S_WAIT: begin
                    if (rsp_done)
                        state <= S_EVAL;
                end
                S_EVAL: begin
                    status_word <= rsp_sw;
                    done_ok <= rsp_ok;
                    state <= S_FIN;
                    case (cur_op)
                        OP_HDR_FETCH: begin
                            // R9 header decode
                            header_byte_first <= rsp_head[63:56];
                            hdr_known <= rsp_ok && rsp_head[63:60] == HDR_FAMILY;
                            hdr_dynamic <= rsp_ok && rsp_head[63:60] == HDR_FAMILY
                                           && rsp_head[63:56] != HDR_STATIC;
                            done_ok <= rsp_ok && rsp_head[63:60] == HDR_FAMILY;
                        end
                        OP_SLOT_RESET: hdr_known <= 1'b0;
                        OP_PROBE: begin
                            // R6 probe and wrap check
                            done_ok <= 1'b1;
                            if (!rsp_ok) begin
                                capacity_pages <= {1'b0, page};
                            end else if (page != 8'h00 && rsp_head == ref_head) begin
                                capacity_pages <= {1'b0, page};
                            end else if (page == PROBE_LAST) begin
                                capacity_pages <= PROBE_FULL;
                            end else begin
                                if (page == 8'h00)
                                    ref_head <= rsp_head;
                                page <= page + PROBE_STEP;
                                idx <= 4'h0;
                                state <= S_SEND;
                            end
                        end
                        default: done_ok <= rsp_ok;
                    endcase
                end
                S_FIN: begin
                    done <= 1'b1;
                    if (refused)
                        done_ok <= 1'b0;
                    req_ready <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    property p_refuse;
        @(posedge core_clk) disable iff (rst)
        (accept && !legal) |-> ##2 (done && !done_ok && refused);
    endproperty
    a_refuse: assert property (p_refuse) else $error("illegal request not refused"); // R26

    property p_sector;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && (cur_op == OP_PAGE_READ || cur_op == OP_PAGE_WRITE) && !cur_multi)
            |-> frame[2] == 8'h00;
    endproperty
    a_sector: assert property (p_sector) else $error("nonzero sector on single-sector tag"); // R1

    property p_page_read;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && cur_op == OP_PAGE_READ) |-> frame[4][1:0] == 2'b00;
    endproperty
    a_page_read: assert property (p_page_read) else $error("page read length not x4"); // R2

    property p_page_write;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && cur_op == OP_PAGE_WRITE) |-> frame_len == 4'h9 && frame[4] == 8'h04;
    endproperty
    a_page_write: assert property (p_page_write) else $error("page update not four bytes"); // R4

    property p_header_first;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && ctat_is_type1(cur_op)) |-> hdr_known;
    endproperty
    a_header_first: assert property (p_header_first) else $error("data access before header"); // R10

    property p_byte_read;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && cur_op == OP_BYTE_READ)
            |-> frame[2] == 8'h00 && !frame[3][7] && frame[4] == 8'h01;
    endproperty
    a_byte_read: assert property (p_byte_read) else $error("byte read address out of range"); // R13

    property p_seg_read;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && cur_op == OP_SEG_READ)
            |-> hdr_dynamic && frame[3][6:0] == 7'h0 && frame[4] == 8'h80;
    endproperty
    a_seg_read: assert property (p_seg_read) else $error("segment read misaligned"); // R14

    property p_block_read;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && cur_op == OP_BLOCK_READ)
            |-> hdr_dynamic && frame[3][2:0] == 3'h0 && frame[4] == 8'h08;
    endproperty
    a_block_read: assert property (p_block_read) else $error("block read misaligned"); // R15

    property p_slot_reset;
        @(posedge core_clk) disable iff (rst)
        (state == S_SEND && cur_op == OP_SLOT_RESET) |-> frame[2] == 8'h10 && frame[3] == 8'h02;
    endproperty
    a_slot_reset: assert property (p_slot_reset) else $error("field reset parameters wrong"); // R17

    property p_probe_wrap;
        @(posedge core_clk) disable iff (rst)
        (state == S_EVAL && cur_op == OP_PROBE && rsp_ok && page != 8'h00 && rsp_head == ref_head)
            |=> state == S_FIN && capacity_pages == {1'b0, $past(page)} ##1 done;
    endproperty
    a_probe_wrap: assert property (p_probe_wrap) else $error("wrap not taken as capacity"); // R6
endmodule

// >>> bench/ctat_coupler_model.sv
// Behavioural coupler on the far side of the host issuer's byte link.
// Assumes each frame ended by tx_last, several for a probe request; read frames answered with data then status word, others with the status word only.
`timescale 1ns/10ps
module ctat_coupler_model
    import ctat_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic slow,
    input wire logic page_tag,
    input wire logic [7:0] hdr_val,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last
);
    logic [7:0] frame [0:15];
    logic got_last;
    int nf;
    int n;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        forever begin
            nf = 0;
            got_last = 1'b0;
            while (!got_last) begin
                @(posedge core_clk);
                if (!rst && tx_valid && tx_ready) begin
                    frame[nf[3:0]] = tx_data;
                    nf++;
                    got_last = tx_last;
                end
                #1;
                tx_ready = got_last ? 1'b0 : (slow ? ~tx_ready : 1'b1);
            end
            n = 0;
            if (frame[1] == INS_READ)
                n = (frame[4] != 8'h00) ? int'(frame[4]) : (page_tag ? 16 : 120);
            repeat (2) @(posedge core_clk);
            #1;
            for (int k = 0; k < n + 2; k++) begin
                rx_valid = 1'b1;
                if (k == n)
                    rx_data = SW_OK[15:8];
                else if (k == n + 1)
                    rx_data = SW_OK[7:0];
                else if (k == 0 && frame[4] == LE_WHOLE_FULL)
                    rx_data = hdr_val;
                else
                    rx_data = {frame[3][3:0], 2'b00} + 8'(k);
                rx_last = (k == n + 1);
                @(posedge core_clk);
                #1;
                if (slow) begin
                    rx_valid = 1'b0;
                    rx_data = ~rx_data;
                    @(posedge core_clk);
                    #1;
                end
            end
            rx_valid = 1'b0;
            rx_last = 1'b0;
            rx_data = ~rx_data;
        end
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the host tag command issuer against the coupler model.
// Assumes the issuer answers each request with a done pulse.
`timescale 1ns/10ps
module testbench
    import ctat_pkg::*;
;
    typedef struct packed {logic rf; logic ok; logic [2:0] n; logic [39:0] hd;} ctat_exp_t;
    logic core_clk, rst, req_valid, req_xor, multi_sector, tx_ready, rx_valid, rx_last;
    logic [3:0] req_op;
    logic [7:0] req_sector, req_len, rx_data, tx_data, header_byte_first, hdr_val;
    logic [15:0] req_addr, status_word;
    logic [63:0] req_data;
    logic req_ready, tx_valid, tx_last, done, done_ok, refused, hdr_known, hdr_dynamic;
    logic [8:0] capacity_pages;
    logic slow, page_tag;
    logic [31:0] seed = 32'h7b23;
    int n_mismatch = 0;
    int n_tests = 0;
    ctat_exp_t expq[$];
    ctat_exp_t e;
    logic [7:0] cap[$];

    ctat_host dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_sector(req_sector), .req_addr(req_addr), .req_len(req_len), .req_xor(req_xor),
        .req_data(req_data), .multi_sector(multi_sector), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .req_ready(req_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .done(done),
        .done_ok(done_ok), .refused(refused), .status_word(status_word),
        .hdr_known(hdr_known), .hdr_dynamic(hdr_dynamic),
        .header_byte_first(header_byte_first), .capacity_pages(capacity_pages));
    ctat_coupler_model partner (.core_clk(core_clk), .rst(rst), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .page_tag(page_tag),
        .hdr_val(hdr_val), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Empty hd means the request must be refused with no link bytes
    task automatic run(input logic [3:0] op, input logic [7:0] sec, input logic [15:0] addr,
            input logic [7:0] len, input logic xr, input logic ok, input int n,
            input logic [39:0] hd);
        int t;
        expq.push_back('{hd == 40'h0, ok, 3'(n), hd});
        while (req_ready !== 1'b1) @(negedge core_clk);
        req_op = op;
        req_sector = sec;
        req_addr = addr;
        req_len = len;
        req_xor = xr;
        req_data = {rnd(), rnd()};
        slow = req_data[0];
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 3000) begin
            @(negedge core_clk);
            t++;
        end
        if (t >= 3000) begin
            check("done", 0, 1);
            final_report();
        end
        @(negedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (req_valid && req_ready) cap = {};
        if (tx_valid && tx_ready) cap.push_back(tx_data);
        if (done) begin
            e = expq.pop_front();
            check("refused", refused, e.rf);
            check("done_ok", done_ok, e.ok);
            if (e.ok) check("status", status_word, SW_OK);
            if (e.rf) check("frame size", cap.size(), 0);
            for (int i = 0; i < e.n; i++) check("frame", cap[i], e.hd[39-8*i -: 8]);
        end
    end

    initial begin
        #3000000;
        check("watchdog", 0, 1);
        final_report();
    end

    initial begin
        rst = 1'b1;
        {req_valid, req_op, req_sector, req_addr, req_len, req_xor, req_data} = '0;
        {multi_sector, slow, page_tag, hdr_val} = {3'b001, 8'h11};
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        run(4'h0, 8'h00, 16'h0004, 8'h00, 0, 1, 5, 40'hffb0000400);
        run(4'h0, 8'h00, 16'h0000, 8'h40, 0, 1, 5, 40'hffb0000040);
        run(4'h0, 8'h00, 16'h0000, 8'h90, 0, 1, 5, 40'hffb0000090);
        run(4'h0, 8'h00, 16'h0000, 8'h06, 0, 0, 0, 40'h0);
        run(4'h1, 8'h00, 16'h0005, 8'h04, 0, 1, 5, 40'hffd6000504);
        run(4'h1, 8'h00, 16'h0005, 8'h03, 0, 0, 0, 40'h0);
        run(4'h0, 8'h01, 16'h0000, 8'h00, 0, 0, 0, 40'h0);
        multi_sector = 1'b1;
        run(4'h0, 8'h01, 16'h0000, 8'h00, 0, 1, 5, 40'hffb0010000);
        multi_sector = 1'b0;
        run(4'h2, 8'h00, 16'h0000, 8'h00, 0, 1, 5, 40'hffb0000000);
        check("capacity", capacity_pages, 9'h010);
        run(4'h5, 8'h00, 16'h0001, 8'h01, 0, 0, 0, 40'h0);
        $display("page tag tests finished");
        page_tag = 1'b0;
        run(4'h3, 8'h00, 16'h0000, 8'h7a, 0, 1, 5, 40'hffb000007a);
        check("hdr", {hdr_known, hdr_dynamic, header_byte_first}, 10'h211);
        run(4'h6, 8'h00, 16'h0000, 8'h80, 0, 0, 0, 40'h0);
        run(4'h7, 8'h00, 16'h0008, 8'h08, 0, 0, 0, 40'h0);
        run(4'h5, 8'h00, 16'h007f, 8'h01, 0, 1, 5, 40'hffb0007f01);
        run(4'h5, 8'h00, 16'h0080, 8'h01, 0, 0, 0, 40'h0);
        run(4'h4, 8'h00, 16'h0000, 8'h78, 0, 1, 5, 40'hffb0000078);
        run(4'h4, 8'h00, 16'h0000, 8'h00, 0, 1, 5, 40'hffb0000000);
        run(4'h4, 8'h00, 16'h0000, 8'h7a, 0, 1, 5, 40'hffb000007a);
        run(4'h8, 8'h00, 16'h0003, 8'h01, 0, 1, 5, 40'hffd6000301);
        run(4'h8, 8'h00, 16'h0003, 8'h01, 1, 1, 5, 40'hffd6800301);
        hdr_val = 8'h12;
        run(4'h3, 8'h00, 16'h0000, 8'h7a, 0, 1, 5, 40'hffb000007a);
        check("hdr", {hdr_known, hdr_dynamic, header_byte_first}, 10'h312);
        run(4'h6, 8'h00, 16'h0100, 8'h80, 0, 1, 5, 40'hffb0010080);
        run(4'h6, 8'h00, 16'h0140, 8'h80, 0, 0, 0, 40'h0);
        run(4'h7, 8'h00, 16'h0208, 8'h08, 0, 1, 5, 40'hffb0020808);
        run(4'h7, 8'h00, 16'h0209, 8'h08, 0, 0, 0, 40'h0);
        run(4'h9, 8'h00, 16'h0010, 8'h08, 1, 1, 5, 40'hffd6801008);
        run(4'h9, 8'h00, 16'h0018, 8'h08, 0, 1, 5, 40'hffd6001808);
        run(4'h9, 8'h00, 16'h0013, 8'h08, 0, 0, 0, 40'h0);
        $display("header tag tests finished");
        run(4'ha, 8'h00, 16'h0000, 8'h00, 0, 1, 4, 40'hfffb100200);
        check("hdr_known", hdr_known, 1'b0);
        run(4'hb, 8'h00, 16'h0000, 8'h00, 0, 1, 4, 40'hfffb200100);
        run(4'hc, 8'h00, 16'h0000, 8'h02, 0, 1, 3, 40'hfffe000000);
        run(4'hc, 8'h01, 16'h0000, 8'h02, 0, 1, 3, 40'hfffe010000);
        hdr_val = 8'h22;
        run(4'h3, 8'h00, 16'h0000, 8'h7a, 0, 0, 5, 40'hffb000007a);
        check("hdr_known", hdr_known, 1'b0);
        run(4'hd, 8'h00, 16'h0000, 8'h00, 0, 0, 0, 40'h0);
        $display("slot and passthrough tests finished");
        final_report();
    end
endmodule
